// ===== rtl/cgsm_top.sv
// gateway status map: control/status word, live list, counters, fatal
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
module cgsm_top #(
    parameter int N_TRANS  = 128,
    parameter int AREA_ADR = 12
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_rst_n,
    input  wire logic [5:0]          i_avs_address,
    input  wire logic                i_avs_read,
    input  wire logic                i_avs_write,
    input  wire logic [31:0]         i_avs_writedata,
    input  wire logic [3:0]          i_avs_byteenable,
    output logic      [31:0]         o_avs_readdata,
    output logic                     o_avs_waitrequest,
    input  wire logic [N_TRANS-1:0]  i_trans_alive,
    input  wire logic                i_rx_ok,
    input  wire logic                i_rx_match,
    input  wire logic                i_tx_ok,
    input  wire logic                i_tx_match,
    input  wire logic                i_fatal,
    input  wire logic [15:0]         i_out_ctrl_word,
    output logic                     o_subnet_run,
    output logic                     o_safe_state,
    output logic                     o_sw_reset,
    output logic [15:0]              o_in_status_word,
    output logic [AREA_ADR-1:0]      o_ll_adr,
    output logic [4:0]               o_ll_bytes,
    output logic [AREA_ADR-1:0]      o_rx_adr,
    output logic [AREA_ADR-1:0]      o_tx_adr,
    output logic [AREA_ADR-1:0]      o_in_free_adr,
    output logic [AREA_ADR-1:0]      o_out_data_adr,
    output logic [15:0]              o_rx_count,
    output logic [15:0]              o_tx_count
);
    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    initial begin
        if (N_TRANS < 8 || N_TRANS > cgsm_pkg::LL_MAX || N_TRANS % 8 != 0) begin
            $error("N_TRANS must be 8..128 in steps of 8");
        end
        if (AREA_ADR < 9 || AREA_ADR > 16) begin
            $error("AREA_ADR must be 9..16");
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [31:0]           config_q;
    logic [AREA_ADR-1:0]   rx_adr_cfg;
    logic [AREA_ADR-1:0]   tx_adr_cfg;
    logic [15:0]           status_word;
    logic [N_TRANS-1:0]    live_q;
    cgsm_pkg::cgsm_state_e state;
    logic [7:0]            restart_cnt;
    logic                  soft_clear;
    logic                  bus_busy;
    logic [15:0]           rx_count;
    logic [15:0]           tx_count;

    wire logic csw_en   = config_q[cgsm_pkg::CFG_CSW_EN];
    wire logic rx_en    = config_q[cgsm_pkg::CFG_RX_EN];
    wire logic tx_en    = config_q[cgsm_pkg::CFG_TX_EN];
    wire logic safe_act = config_q[cgsm_pkg::CFG_SAFE_ACT];
    wire logic auto_adr = config_q[cgsm_pkg::CFG_AUTO_ADR];
    wire logic [4:0] ll_field =
        config_q[cgsm_pkg::CFG_LL_LSB +: cgsm_pkg::CFG_LL_W];

    // byte-lane merge, used only by the config register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // live list size in bytes, clamped to what the block holds
    function automatic logic [4:0] ll_size(input logic [4:0] f);
        logic [4:0] lim;
        lim = 5'(N_TRANS / cgsm_pkg::LL_STEP);
        return (f > lim) ? lim : f;
    endfunction

    wire logic wr_hit = i_avs_write && !bus_busy;
    wire logic rd_hit = i_avs_read && !bus_busy;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            config_q <= cgsm_pkg::CONFIG_RST;
        end else if (wr_hit && i_avs_address == cgsm_pkg::OFS_CONFIG) begin
            config_q <= merge(config_q, i_avs_writedata, i_avs_byteenable);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rx_adr_cfg <= '0;
            tx_adr_cfg <= '0;
        end else if (wr_hit && i_avs_address == cgsm_pkg::OFS_CNT_ADDR) begin
            rx_adr_cfg <= i_avs_writedata[AREA_ADR-1:0];
            tx_adr_cfg <= i_avs_writedata[16 +: AREA_ADR];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            status_word <= '0;
        end else if (wr_hit && i_avs_address == cgsm_pkg::OFS_CTRL_WD) begin
            status_word <= i_avs_writedata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // input area layout
    // ----------------------------------------------------------------
    logic [AREA_ADR-1:0] ll_start;
    logic [AREA_ADR-1:0] ll_end;
    logic [AREA_ADR-1:0] rx_def;
    logic [AREA_ADR-1:0] tx_def;
    always_comb begin
        ll_start = csw_en ? AREA_ADR'(cgsm_pkg::CSW_BYTES) : '0;
        ll_end   = ll_start + AREA_ADR'(ll_size(ll_field));
        rx_def   = ll_end;
        tx_def   = ll_end + (rx_en ? AREA_ADR'(cgsm_pkg::CNT_BYTES)
                                   : AREA_ADR'(0));
    end

    // ----------------------------------------------------------------
    // live list sampling
    // ----------------------------------------------------------------
    // one bit per transaction, index equals transaction number
    genvar g;
    generate
        for (g = 0; g < N_TRANS; g++) begin : g_live
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    live_q[g] <= 1'b0;
                end else begin
                    live_q[g] <= (g < 8 * ll_size(ll_field)) &&
                                 i_trans_alive[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    cgsm_counter #(.WIDTH(16)) u_rx_cnt (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (i_rst_n),
        .i_clear      (soft_clear),
        .i_enable     (rx_en && state == cgsm_pkg::CGSM_RUN),
        .i_event      (i_rx_ok),
        .i_configured (i_rx_match),
        .o_count      (rx_count)
    );

    cgsm_counter #(.WIDTH(16)) u_tx_cnt (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (i_rst_n),
        .i_clear      (soft_clear),
        .i_enable     (tx_en && state == cgsm_pkg::CGSM_RUN),
        .i_event      (i_tx_ok),
        .i_configured (i_tx_match),
        .o_count      (tx_count)
    );

    // ----------------------------------------------------------------
    // fatal event handling
    // ----------------------------------------------------------------
    // safe state is only left by a hard reset, never by software
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state       <= cgsm_pkg::CGSM_RUN;
            restart_cnt <= '0;
        end else begin
            unique case (state)
                cgsm_pkg::CGSM_RUN: begin
                    if (i_fatal) begin
                        state <= safe_act ? cgsm_pkg::CGSM_SAFE
                                          : cgsm_pkg::CGSM_RESTART;
                        restart_cnt <= 8'(cgsm_pkg::RESTART_CYC);
                    end
                end
                cgsm_pkg::CGSM_RESTART: begin
                    if (restart_cnt == 8'h01) begin
                        state <= cgsm_pkg::CGSM_RUN;
                    end
                    restart_cnt <= restart_cnt - 8'h01;
                end
                cgsm_pkg::CGSM_SAFE: begin
                    state <= cgsm_pkg::CGSM_SAFE;
                end
                default: begin
                    state <= cgsm_pkg::CGSM_SAFE;
                end
            endcase
        end
    end

    assign soft_clear = (state == cgsm_pkg::CGSM_RESTART);

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_subnet_run     <= 1'b0;
            o_safe_state     <= 1'b0;
            o_sw_reset       <= 1'b0;
            o_in_status_word <= '0;
            o_ll_adr         <= '0;
            o_ll_bytes       <= '0;
            o_rx_adr         <= '0;
            o_tx_adr         <= '0;
            o_in_free_adr    <= '0;
            o_out_data_adr   <= '0;
            o_rx_count       <= '0;
            o_tx_count       <= '0;
        end else begin
            // start-up mode is honoured only with the control word on
            o_subnet_run <= (state == cgsm_pkg::CGSM_RUN) &&
                            (csw_en ? (config_q[cgsm_pkg::CFG_RUN_MODE] ||
                                       i_out_ctrl_word[0])
                                    : 1'b1);
            o_safe_state     <= (state == cgsm_pkg::CGSM_SAFE);
            o_sw_reset       <= soft_clear;
            o_in_status_word <= csw_en ? status_word : 16'h0000;
            o_ll_adr         <= ll_start;
            o_ll_bytes       <= ll_size(ll_field);
            o_rx_adr         <= auto_adr ? rx_def : rx_adr_cfg;
            o_tx_adr         <= auto_adr ? tx_def : tx_adr_cfg;
            o_in_free_adr    <= tx_def + (tx_en ?
                                AREA_ADR'(cgsm_pkg::CNT_BYTES) : AREA_ADR'(0));
            o_out_data_adr   <= csw_en ? AREA_ADR'(cgsm_pkg::CSW_BYTES)
                                       : '0;
            o_rx_count       <= rx_en ? rx_count : 16'h0000;
            o_tx_count       <= tx_en ? tx_count : 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // bus slave: one wait cycle per access, reads registered
    // ----------------------------------------------------------------
    // padded copy so a 32-bit slice never runs past a short live list
    logic [127:0] live_wide;
    assign live_wide = 128'(live_q);

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (i_avs_address)
            cgsm_pkg::OFS_CONFIG:   next_rdata = config_q;
            cgsm_pkg::OFS_CNT_ADDR: next_rdata = {16'(tx_adr_cfg),
                                                  16'(rx_adr_cfg)};
            cgsm_pkg::OFS_STATUS:   next_rdata = {24'h000000, 4'h0,
                                                  o_safe_state,
                                                  o_sw_reset,
                                                  o_subnet_run, csw_en};
            cgsm_pkg::OFS_COUNTERS: next_rdata = {tx_count, rx_count};
            cgsm_pkg::OFS_CTRL_WD:  next_rdata = {i_out_ctrl_word,
                                                  status_word};
            cgsm_pkg::OFS_FATAL:    next_rdata = {30'h00000000, state};
            default: begin
                if (i_avs_address >= cgsm_pkg::OFS_LIVE0 &&
                    i_avs_address < cgsm_pkg::OFS_LIVE0 + 6'(N_TRANS / 8)) begin
                    next_rdata = live_wide[i_avs_address[3:2] * 32 +: 32];
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            bus_busy          <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= '0;
        end else begin
            bus_busy          <= (rd_hit || wr_hit);
            o_avs_waitrequest <= !(rd_hit || wr_hit);
            if (rd_hit) begin
                o_avs_readdata <= next_rdata;
            end
        end
    end
endmodule

// ===== rtl/cgsm_pkg.sv
// constants for the gateway status map block
// Notes on behaviour
// - control/status word takes first two bytes
// - start-up run or idle only with control word
// - live list at area start or after status
// - live list covers 8 to 128, steps 8; the code also allows 0 when ll_field is 0, its reset value
// - one alive bit per covered transaction
// - transaction number selects its live bit
// - count successful received and transmitted messages
// - only configured messages advance a counter
// - receive and transmit counters enable separately
// - receive counter takes two bytes
// - transmit counter takes two bytes
// - safe-state action locks in safe state
// - software reset action restarts automatically
package cgsm_pkg;
    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [5:0] OFS_CONFIG   = 6'h00;
    localparam logic [5:0] OFS_CNT_ADDR = 6'h04;
    localparam logic [5:0] OFS_STATUS   = 6'h08;
    localparam logic [5:0] OFS_COUNTERS = 6'h0C;
    localparam logic [5:0] OFS_CTRL_WD  = 6'h10;
    localparam logic [5:0] OFS_FATAL    = 6'h14;
    localparam logic [5:0] OFS_LIVE0    = 6'h20;
    // ----------------------------------------------------------------
    // config field positions
    // ----------------------------------------------------------------
    localparam int CFG_CSW_EN   = 0;
    localparam int CFG_RUN_MODE = 1;
    localparam int CFG_RX_EN    = 2;
    localparam int CFG_TX_EN    = 3;
    localparam int CFG_SAFE_ACT = 4;
    localparam int CFG_LL_LSB   = 8;
    localparam int CFG_LL_W     = 5;
    localparam int CFG_AUTO_ADR = 16;
    // ----------------------------------------------------------------
    // reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [31:0] CONFIG_RST   = 32'h0001_0000;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
    localparam int          CSW_BYTES    = 2;
    localparam int          CNT_BYTES    = 2;
    localparam int          LL_STEP      = 8;
    localparam int          LL_MAX       = 128;
    localparam int          RESTART_NS   = 400;
    localparam int          CLK_NS       = 40;
    localparam int          RESTART_CYC  = (RESTART_NS + CLK_NS - 1) / CLK_NS;
    // ----------------------------------------------------------------
    // operating states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CGSM_RUN     = 2'b00,
        CGSM_RESTART = 2'b01,
        CGSM_SAFE    = 2'b11
    } cgsm_state_e;
endpackage

// ===== rtl/cgsm_counter.sv
// wrapping 16-bit message counter with its own enable
module cgsm_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_clear,
    input  wire logic             i_enable,
    input  wire logic             i_event,
    input  wire logic             i_configured,
    output logic      [WIDTH-1:0] o_count
);
    initial begin
        if (WIDTH < 1) begin
            $error("counter width must be positive");
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || i_clear) begin
            o_count <= '0;
        end else if (i_enable && i_event && i_configured) begin
            o_count <= o_count + 1'b1;
        end
    end
endmodule

// ===== tb/cgsm_monitor.sv
// checker for the gateway status map ports
module cgsm_monitor (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_rx_ok,
    input wire logic        i_rx_match,
    input wire logic        i_tx_ok,
    input wire logic        i_tx_match,
    input wire logic        o_safe_state,
    input wire logic        o_sw_reset,
    input wire logic [15:0] o_rx_count,
    input wire logic [15:0] o_tx_count
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------------------------------
    // sequences and properties
    // ----------------------------------------------------------------
    // restart must end on its own, not wait for the fieldbus side
    sequence s_restart;
        o_sw_reset [*8] ##[1:4] !o_sw_reset;
    endsequence
    a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_wait_answer: assert property ((i_avs_read || i_avs_write)
        && o_avs_waitrequest |-> ##[1:3] !o_avs_waitrequest)
        else $error("bus request not answered");
    a_wait_idle: assert property (!(i_avs_read || i_avs_write)
        |=> o_avs_waitrequest) else $error("answer without request");
    a_safe_lock: assert property (o_safe_state |=> o_safe_state)
        else $error("safe state left without reset");
    a_restart_len: assert property ($rose(o_sw_reset) |-> s_restart)
        else $error("restart length wrong");
    a_restart_clear: assert property ($fell(o_sw_reset) |->
        o_rx_count == 16'h0000 && o_tx_count == 16'h0000)
        else $error("counters not cleared by restart");
    a_rx_step: assert property ($changed(o_rx_count) |->
        o_rx_count == 16'($past(o_rx_count) + 16'h0001)
        || o_rx_count == 16'h0000) else $error("receive count jumped");
    a_rx_cause: assert property ($changed(o_rx_count)
        && o_rx_count != 16'h0000 |-> $past(i_rx_ok && i_rx_match)
        || $past(i_rx_ok && i_rx_match, 2)
        || $past(i_rx_ok && i_rx_match, 3))
        else $error("receive count without matched message");
    a_tx_cause: assert property ($changed(o_tx_count)
        && o_tx_count != 16'h0000 |-> $past(i_tx_ok && i_tx_match)
        || $past(i_tx_ok && i_tx_match, 2)
        || $past(i_tx_ok && i_tx_match, 3))
        else $error("transmit count without matched message");
endmodule

bind cgsm_top cgsm_monitor u_mon (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_rx_ok(i_rx_ok), .i_rx_match(i_rx_match),
    .i_tx_ok(i_tx_ok), .i_tx_match(i_tx_match),
    .o_safe_state(o_safe_state), .o_sw_reset(o_sw_reset),
    .o_rx_count(o_rx_count), .o_tx_count(o_tx_count)
);

// ===== tb/cgsm_fieldbus_model.sv
// fieldbus master model: drives the control word of the output area
module cgsm_fieldbus_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_run_req,
    output logic      [15:0] o_ctrl_word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_ctrl_word = 16'h0000;
    // spare bits toggle so no check leans on a settled unused field
    always @(posedge i_core_clk) begin
        o_ctrl_word <= {~o_ctrl_word[15:1], i_run_req};
    end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the gateway status map
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NT = 16;
    logic          i_core_clk = 1'b0;
    logic          i_rst_n = 1'b0;
    logic [5:0]    adr = 6'h00;
    logic          rd = 1'b0, wr = 1'b0, fatal = 1'b0, run_req = 1'b0;
    logic          rx_ok = 1'b0, rx_m = 1'b0, tx_ok = 1'b0, tx_m = 1'b0;
    logic [31:0]   wdat = 32'h0000_0000, rdata, rv;
    logic [NT-1:0] alive = '0;
    logic [15:0]   ctrl, rxc, txc;
    logic [11:0]   ll_adr, rx_adr, tx_adr, out_adr;
    logic [4:0]    ll_bytes;
    logic          wreq, run, safe, swr;
    int            n_errors = 0, comparisons = 0, seed = 32'hfff1;
    int            exp_rx = 0, exp_tx = 0, rx_en = 0, tx_en = 0, t;
    always #20 i_core_clk = ~i_core_clk;
    cgsm_fieldbus_model u_fb (.i_core_clk(i_core_clk),
        .i_run_req(run_req), .o_ctrl_word(ctrl));
    cgsm_top #(.N_TRANS(NT), .AREA_ADR(12)) u_dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_trans_alive(alive),
        .i_rx_ok(rx_ok), .i_rx_match(rx_m), .i_tx_ok(tx_ok),
        .i_tx_match(tx_m), .i_fatal(fatal), .i_out_ctrl_word(ctrl),
        .o_subnet_run(run), .o_safe_state(safe), .o_sw_reset(swr),
        .o_in_status_word(), .o_ll_adr(ll_adr), .o_ll_bytes(ll_bytes),
        .o_rx_adr(rx_adr), .o_tx_adr(tx_adr), .o_in_free_adr(),
        .o_out_data_adr(out_adr), .o_rx_count(rxc), .o_tx_count(txc));
    // ----------------------------------------------------------------
    // compare, bus and traffic tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_cnt();
        chk({16'h0000, rxc}, {16'h0000, 16'(exp_rx)});
        chk({16'h0000, txc}, {16'h0000, 16'(exp_tx)});
    endtask
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        rv = rdata;
        if (n == 20) chk(1'b0, 1'b1);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_core_clk);
    endtask
    // model counts only matched messages of enabled counters
    task automatic traffic(input int n, input logic hold);
        logic [3:0] r;
        repeat (n) begin
            r = 4'($random(seed));
            rx_ok <= hold | r[0];
            rx_m <= hold | r[1];
            tx_ok <= !hold & r[2];
            tx_m <= r[3];
            exp_rx += rx_en & (hold | (r[0] & r[1]));
            exp_tx += tx_en & !hold & r[2] & r[3];
            @(posedge i_core_clk);
        end
        rx_ok <= 1'b0;
        tx_ok <= 1'b0;
        repeat (4) @(posedge i_core_clk);
    endtask
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        #(40 * 90000);
        n_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        chk(wreq, 1'b1);
        bus(0, cgsm_pkg::OFS_CONFIG, 0);
        chk(rv, cgsm_pkg::CONFIG_RST);
        bus(1, 6'h18, 32'hFFFF_FFFF);
        bus(0, 6'h18, 0);
        chk(rv, 0);
        for (int k = 0; k < 6; k++) begin
            t = (k < 2) ? 1 : (k < 4) ? 2 : 16;
            bus(1, cgsm_pkg::OFS_CONFIG, (t << 8) | (k % 2));
            repeat (2) @(posedge i_core_clk);
            chk(out_adr, 2 * (k % 2));
            chk(ll_adr, 2 * (k % 2));
            chk(ll_bytes, (t > NT / 8) ? NT / 8 : t);
        end
        repeat (3) begin
            alive <= NT'($random(seed));
            repeat (3) @(posedge i_core_clk);
            bus(0, cgsm_pkg::OFS_LIVE0, 0);
            chk(rv[NT-1:0], alive);
        end
        for (int k = 0; k < 4; k++) begin
            bus(1, cgsm_pkg::OFS_CONFIG, 32'h0000_0200 | (k != 2)
                | ((k == 3) << 1));
            run_req <= (k == 1);
            repeat (4) @(posedge i_core_clk);
            chk(run, k != 0);
        end
        bus(1, cgsm_pkg::OFS_CONFIG, 32'h0001_020D);
        repeat (2) @(posedge i_core_clk);
        chk({rx_adr, tx_adr}, {12'h004, 12'h006});
        bus(1, cgsm_pkg::OFS_CNT_ADDR, 32'h0010_0020);
        bus(1, cgsm_pkg::OFS_CONFIG, 32'h0000_0205);
        rx_en = 1;
        repeat (2) @(posedge i_core_clk);
        chk({rx_adr, tx_adr}, {12'h020, 12'h010});
        traffic(60, 0);
        chk_cnt();
        bus(1, cgsm_pkg::OFS_CONFIG, 32'h0000_020D);
        tx_en = 1;
        traffic(60, 0);
        chk_cnt();
        traffic(65536 - exp_rx + 3, 1);
        exp_rx = exp_rx % 65536;
        chk_cnt();
        bus(0, cgsm_pkg::OFS_COUNTERS, 0);
        chk(rv, {16'(exp_tx), 16'(exp_rx)});
        fatal <= 1'b1;
        @(posedge i_core_clk);
        fatal <= 1'b0;
        t = 0;
        while (swr !== 1'b1 && t < 20) begin
            @(posedge i_core_clk);
            t++;
        end
        t = 0;
        while (swr === 1'b1 && t < 50) begin
            @(posedge i_core_clk);
            t++;
        end
        chk(t, cgsm_pkg::RESTART_CYC);
        exp_rx = 0;
        exp_tx = 0;
        repeat (2) @(posedge i_core_clk);
        chk_cnt();
        bus(1, cgsm_pkg::OFS_CONFIG, 32'h0000_020D);
        traffic(30, 0);
        chk_cnt();
        bus(1, cgsm_pkg::OFS_CONFIG, 32'h0000_021D);
        fatal <= 1'b1;
        @(posedge i_core_clk);
        fatal <= 1'b0;
        repeat (40) @(posedge i_core_clk);
        chk(safe, 1'b1);
        bus(0, cgsm_pkg::OFS_FATAL, 0);
        chk(rv[1:0], cgsm_pkg::CGSM_SAFE);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        chk(safe, 1'b0);
        report_and_stop();
    end
endmodule
